// File: common/epvid_defs.vh
// Register map, field positions, reset values and lamp codes of the egress
// tag-insertion and power/lamp configuration block.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef EPVID_DEFS_VH
`define EPVID_DEFS_VH

// Printed offsets 0xC2 and 0xC3 are not multiples of four: kept as indices.
`define EPVID_IDX_INSERT      8'hC2
`define EPVID_IDX_PWR_LAMP    8'hC3
`define EPVID_ADDR_INSERT     10'h308
`define EPVID_ADDR_PWR_LAMP   10'h30C

// Insert register fields.
`define EPVID_BIT_P1_TO_P2    5
`define EPVID_BIT_P1_TO_P3    4
`define EPVID_BIT_P2_TO_P1    3
`define EPVID_BIT_P2_TO_P3    2
`define EPVID_BIT_P3_TO_P1    1
`define EPVID_BIT_P3_TO_P2    0
`define EPVID_INSERT_MASK     8'h3F
`define EPVID_INSERT_RESET    8'h00

// Power and lamp register fields.
`define EPVID_BIT_CPU_PD      7
`define EPVID_BIT_SW_PD       6
`define EPVID_LAMP_MSB        5
`define EPVID_LAMP_LSB        4
`define EPVID_PWR_MASK        8'hF0
`define EPVID_PWR_RESET       8'h00

// Lamp mode codes.
`define EPVID_LAMP_LACT_SPD   2'h0
`define EPVID_LAMP_LNK_ACT    2'h1
`define EPVID_LAMP_LACT_DPX   2'h2
`define EPVID_LAMP_LNK_DPX    2'h3

`endif

// File: rtl/epvid_lamp_mux.v
// Lamp selector for one port: picks what each of the two lamps shows.
// Assumes status inputs synchronous to hclk; outputs registered.
`timescale 1ns/1ps
`include "epvid_defs.vh"

module epvid_lamp_mux (
  // Clock and reset
  input  wire       hclk,
  input  wire       hresetn,
  // Mode and port status
  input  wire [1:0] mode,
  input  wire       link,
  input  wire       act,
  input  wire       speed_100,
  input  wire       full_duplex,
  // Lamps, high means lit
  output reg        lamp0_ff,
  output reg        lamp1_ff
);

  reg nxt_lamp0;
  reg nxt_lamp1;

  // ==========================================================================
  // Selection
  always @* begin
    // In the LACT modes lamp0 is lit on link and dark for as long as act is high; the LNK modes light it on link alone.
    nxt_lamp0 = link & ~act;
    nxt_lamp1 = link & speed_100;
    case (mode)
      `EPVID_LAMP_LACT_SPD: begin
        nxt_lamp0 = link & ~act;
        nxt_lamp1 = link & speed_100;
      end
      `EPVID_LAMP_LNK_ACT: begin
        nxt_lamp0 = link;
        nxt_lamp1 = act;
      end
      `EPVID_LAMP_LACT_DPX: begin
        nxt_lamp0 = link & ~act;
        nxt_lamp1 = link & full_duplex;
      end
      default: begin
        nxt_lamp0 = link;
        nxt_lamp1 = link & full_duplex;
      end
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lamp0_ff <= 1'b0;
      lamp1_ff <= 1'b0;
    end else begin
      lamp0_ff <= nxt_lamp0;
      lamp1_ff <= nxt_lamp1;
    end
  end

endmodule // epvid_lamp_mux

// File: rtl/epvid_cfg_top.v
// Egress source-VLAN insert enables and power/lamp mode registers behind an
// AHB-Lite slave, with per-port lamp drivers.
// Assumes a single AHB-Lite master doing whole-word single transfers.
//
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "epvid_defs.vh"

module epvid_cfg_top #(
  parameter NPORTS = 3
) (
  // AHB-Lite slave
  input  wire              hclk,
  input  wire              hresetn,
  input  wire              hsel,
  input  wire [31:0]       haddr,
  input  wire [1:0]        htrans,
  input  wire              hwrite,
  input  wire [2:0]        hsize,
  input  wire [31:0]       hwdata,
  input  wire              hready,
  output reg  [31:0]       hrdata,
  output reg               hreadyout,
  output reg               hresp,
  // Per-frame tag decision: source and egress port, one-hot over three ports
  input  wire [2:0]        frm_src,
  input  wire [2:0]        frm_dst,
  input  wire              frm_untagged,
  output reg               insert_pvid_ff,
  // Power-down enables
  output reg               cpu_clk_pd_en_ff,
  output reg               sw_clk_pd_en_ff,
  // Port status and lamps
  input  wire [NPORTS-1:0] port_link,
  input  wire [NPORTS-1:0] port_act,
  input  wire [NPORTS-1:0] port_speed_100,
  input  wire [NPORTS-1:0] port_full_duplex,
  output wire [NPORTS-1:0] indicator_out_0,
  output wire [NPORTS-1:0] indicator_out_1
);

  // ==========================================================================
  // Registers and bus decode
  reg  [7:0] insert_ff;
  reg  [7:0] pwr_ff;
  reg        wr_pend_ff;
  reg  [9:0] wr_addr_ff;
  reg        nxt_insert_pvid;
  reg [31:0] nxt_hrdata;
  reg  [7:0] nxt_insert;
  reg  [7:0] nxt_pwr;
  wire       xfer;
  wire       rd_take;
  wire [9:0] a_lo;
  wire [7:0] wr_byte;
  wire       insert_wr;
  wire       pwr_wr;

  assign xfer      = hsel & hready & htrans[1];
  assign rd_take   = xfer & ~hwrite;
  assign a_lo      = haddr[9:0];
  assign wr_byte   = hwdata[7:0];
  // The write strobes fire in the data phase, when hwdata stands on the bus.
  assign insert_wr = wr_pend_ff & (wr_addr_ff == `EPVID_ADDR_INSERT);
  assign pwr_wr    = wr_pend_ff & (wr_addr_ff == `EPVID_ADDR_PWR_LAMP);

  // ==========================================================================
  // Register next values
  // Reserved bits are held at zero whatever software writes.
  always @* begin
    nxt_insert = insert_ff;
    if (insert_wr) begin
      nxt_insert = wr_byte & `EPVID_INSERT_MASK;
    end
  end

  always @* begin
    nxt_pwr = pwr_ff;
    if (pwr_wr) begin
      nxt_pwr = wr_byte & `EPVID_PWR_MASK;
    end
  end

  // ==========================================================================
  // Read data
  // A read taken in the data phase of a write sees the value being written,
  // so a write followed at once by a read of the same register is not stale.
  always @* begin
    nxt_hrdata = 32'h00000000;
    if (a_lo == `EPVID_ADDR_INSERT) begin
      nxt_hrdata = {24'h000000, nxt_insert};
    end else if (a_lo == `EPVID_ADDR_PWR_LAMP) begin
      nxt_hrdata = {24'h000000, nxt_pwr};
    end
  end

  // ==========================================================================
  // Bus pipeline
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 10'h000;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
    end else begin
      wr_pend_ff <= xfer & hwrite;
      if (xfer) begin
        wr_addr_ff <= a_lo;
      end
      // Every transfer ends with no wait state and an OKAY response.
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
    end
  end

  // Read data stands until the next read is taken.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (rd_take) begin
      hrdata <= nxt_hrdata;
    end
  end

  // ==========================================================================
  // Configuration registers
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      insert_ff <= `EPVID_INSERT_RESET;
    end else begin
      insert_ff <= nxt_insert;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pwr_ff <= `EPVID_PWR_RESET;
    end else begin
      pwr_ff <= nxt_pwr;
    end
  end

  // ==========================================================================
  // Power-down enables
  // The enables lag the register by one cycle, so the clock-gating cells are
  // fed from flops of their own.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cpu_clk_pd_en_ff <= 1'b0;
      sw_clk_pd_en_ff  <= 1'b0;
    end else begin
      cpu_clk_pd_en_ff <= pwr_ff[`EPVID_BIT_CPU_PD];
      sw_clk_pd_en_ff  <= pwr_ff[`EPVID_BIT_SW_PD];
    end
  end

  // ==========================================================================
  // Egress tag decision
  wire       en_p1_to_p2;
  wire       en_p1_to_p3;
  wire       en_p2_to_p1;
  wire       en_p2_to_p3;
  wire       en_p3_to_p1;
  wire       en_p3_to_p2;

  assign en_p1_to_p2 = insert_ff[`EPVID_BIT_P1_TO_P2];
  assign en_p1_to_p3 = insert_ff[`EPVID_BIT_P1_TO_P3];
  assign en_p2_to_p1 = insert_ff[`EPVID_BIT_P2_TO_P1];
  assign en_p2_to_p3 = insert_ff[`EPVID_BIT_P2_TO_P3];
  assign en_p3_to_p1 = insert_ff[`EPVID_BIT_P3_TO_P1];
  assign en_p3_to_p2 = insert_ff[`EPVID_BIT_P3_TO_P2];

  // A frame with several source bits set is judged by its lowest port.
  always @* begin
    nxt_insert_pvid = 1'b0;
    if (frm_untagged) begin
      if (frm_src[0]) begin
        nxt_insert_pvid = (frm_dst[1] & en_p1_to_p2) |
                          (frm_dst[2] & en_p1_to_p3);
      end else if (frm_src[1]) begin
        nxt_insert_pvid = (frm_dst[0] & en_p2_to_p1) |
                          (frm_dst[2] & en_p2_to_p3);
      end else if (frm_src[2]) begin
        nxt_insert_pvid = (frm_dst[0] & en_p3_to_p1) |
                          (frm_dst[1] & en_p3_to_p2);
      end
    end
  end

  // The decision reaches the egress logic one cycle after the frame inputs.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      insert_pvid_ff <= 1'b0;
    end else begin
      insert_pvid_ff <= nxt_insert_pvid;
    end
  end

  // ==========================================================================
  // Lamps
  genvar gi;
  generate
    for (gi = 0; gi < NPORTS; gi = gi + 1) begin : g_lamp
      epvid_lamp_mux u_lamp (
        .hclk        (hclk),
        .hresetn     (hresetn),
        .mode        (pwr_ff[`EPVID_LAMP_MSB:`EPVID_LAMP_LSB]),
        .link        (port_link[gi]),
        .act         (port_act[gi]),
        .speed_100   (port_speed_100[gi]),
        .full_duplex (port_full_duplex[gi]),
        .lamp0_ff    (indicator_out_0[gi]),
        .lamp1_ff    (indicator_out_1[gi])
      );
    end
  endgenerate

endmodule // epvid_cfg_top

// File: tb/epvid_cfg_asserts.sv
// Port checker for the tag-insertion and power/lamp configuration block.
// Assumes it is bound into epvid_cfg_top and sees only its ports.
`timescale 1ns/1ps
// ==========================================================
// Checker
module epvid_cfg_asserts #(parameter NPORTS = 3) (
  input wire              hclk,
  input wire              hresetn,
  input wire              hsel,
  input wire [31:0]       haddr,
  input wire [1:0]        htrans,
  input wire              hwrite,
  input wire [31:0]       hwdata,
  input wire              hready,
  input wire              hreadyout,
  input wire              hresp,
  input wire [2:0]        frm_src,
  input wire [2:0]        frm_dst,
  input wire              frm_untagged,
  input wire              insert_pvid_ff,
  input wire              cpu_clk_pd_en_ff,
  input wire              sw_clk_pd_en_ff,
  input wire [NPORTS-1:0] port_link,
  input wire [NPORTS-1:0] port_act,
  input wire [NPORTS-1:0] indicator_out_0,
  input wire [NPORTS-1:0] indicator_out_1
);
  wire pwr_wr = hsel & hready & htrans[1] & hwrite & (haddr[9:0] == 10'h30C);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_resp_okay: assert property (!hresp) else $error("error response seen");
  a_ready_zero_wait: assert property (hreadyout) else $error("wait state seen");
  a_insert_untagged: assert property (insert_pvid_ff |-> $past(frm_untagged))
    else $error("tag added to tagged frame");
  a_insert_cross: assert property (insert_pvid_ff |-> ($past(frm_src & frm_dst) == 3'h0))
    else $error("tag added on same port");
  a_cpu_pd_write: assert property (pwr_wr |-> ##3 (cpu_clk_pd_en_ff == $past(hwdata[7], 2)))
    else $error("cpu power-down enable wrong");
  a_sw_pd_write: assert property (pwr_wr |-> ##3 (sw_clk_pd_en_ff == $past(hwdata[6], 2)))
    else $error("core power-down enable wrong");
  a_lamp0_link: assert property ((indicator_out_0 & ~$past(port_link)) == '0)
    else $error("lamp0 lit without link");
  a_lamp1_cause: assert property ((indicator_out_1 & ~$past(port_link | port_act)) == '0)
    else $error("lamp1 lit without cause");
endmodule // epvid_cfg_asserts

bind epvid_cfg_top epvid_cfg_asserts #(.NPORTS(NPORTS)) u_asserts (.hclk, .hresetn, .hsel, .haddr,
  .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .frm_src, .frm_dst, .frm_untagged,
  .insert_pvid_ff, .cpu_clk_pd_en_ff, .sw_clk_pd_en_ff, .port_link, .port_act, .indicator_out_0,
  .indicator_out_1);

// File: tb/tb_epvid_cfg_top.sv
// Self-checking bench for epvid_cfg_top.
// Assumes a zero-wait AHB-Lite slave and registered outputs.
`timescale 1ns/1ps
// ==========================================================
// Bench
module tb_epvid_cfg_top;
  logic        hclk, hresetn, hwrite, hreadyout, hresp, frm_untagged;
  logic        insert_pvid_ff, cpu_clk_pd_en_ff, sw_clk_pd_en_ff;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  frm_src, frm_dst, port_link, port_act, port_speed_100, port_full_duplex;
  logic [2:0]  indicator_out_0, indicator_out_1;
  int          mismatches, samples_checked;
  epvid_cfg_top u_dut (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .frm_src, .frm_dst, .frm_untagged,
    .insert_pvid_ff, .cpu_clk_pd_en_ff, .sw_clk_pd_en_ff, .port_link, .port_act, .port_speed_100,
    .port_full_duplex, .indicator_out_0, .indicator_out_1);
  task automatic chk(input [31:0] g, input [31:0] e);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic xfer(input [31:0] a, input w, input [31:0] d);
    haddr <= a; hwrite <= w; htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic test_reset;
    xfer(32'h304, 1, 32'hFF); // Unmapped write must be ignored.
    xfer(32'h304, 0, 0); chk(rd, 0);
    xfer(32'h308, 0, 0); chk(rd, 0);
    xfer(32'h30C, 0, 0); chk(rd, 0);
    chk({cpu_clk_pd_en_ff, sw_clk_pd_en_ff}, 0);
  endtask
  task automatic test_insert;
    logic [5:0] tbl [6] = '{6'h22, 6'h21, 6'h14, 6'h11, 6'h0C, 6'h0A};
    for (int b = 0; b < 6; b++) begin
      xfer(32'h308, 1, 1 << b); xfer(32'h308, 0, 0); chk(rd, 1 << b);
      for (int s = 0; s < 3; s++) for (int d = 0; d < 3; d++) for (int u = 0; u < 2; u++) begin
        frm_src <= 3'(1 << s); frm_dst <= 3'(1 << d); frm_untagged <= u[0];
        repeat (2) @(posedge hclk);
        chk(insert_pvid_ff, u[0] && ({3'(1 << s), 3'(1 << d)} == tbl[b]));
      end
    end
  endtask
  task automatic test_power;
    logic [7:0] v [4] = '{8'hA0, 8'h50, 8'hF0, 8'h00};
    for (int i = 0; i < 4; i++) begin
      xfer(32'h30C, 1, v[i]); xfer(32'h30C, 0, 0); chk(rd, v[i]);
      repeat (2) @(posedge hclk);
      chk({cpu_clk_pd_en_ff, sw_clk_pd_en_ff}, v[i][7:6]);
    end
  endtask
  task automatic test_lamps;
    logic [3:0] q;
    logic       e0, e1;
    logic [2:0] lk, ac, sp, fd;
    for (int m = 0; m < 4; m++) begin
      xfer(32'h30C, 1, m << 4);
      for (int st = 0; st < 16; st++) begin
        for (int p = 0; p < 3; p++) begin
          q = 4'(st + 5 * p);
          {fd[p], sp[p], ac[p], lk[p]} = q;
        end
        port_link <= lk;
        port_act <= ac;
        port_speed_100 <= sp;
        port_full_duplex <= fd;
        repeat (2) @(posedge hclk);
        for (int p = 0; p < 3; p++) begin
          q = 4'(st + 5 * p);
          e0 = m[0] ? q[0] : (q[0] & ~q[1]);
          e1 = m[1] ? (q[0] & q[3]) : (m[0] ? q[1] : (q[0] & q[2]));
          chk({indicator_out_1[p], indicator_out_0[p]}, {e1, e0});
        end
      end
    end
  endtask
  task automatic finish_test;
    $display("checked %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    hclk = 0;
    forever #50 hclk = ~hclk;
  end
  initial begin
    hresetn = 0; haddr = 0; hwrite = 0; htrans = 0; hwdata = 0; frm_src = 0; frm_dst = 0;
    frm_untagged = 0; port_link = 0; port_act = 0; port_speed_100 = 0; port_full_duplex = 0;
    repeat (10) @(posedge hclk);
    hresetn <= 1;
    @(posedge hclk);
    test_reset; test_insert; test_power; test_lamps;
    finish_test;
  end
  initial begin
    repeat (5000) @(posedge hclk);
    mismatches++;
    finish_test;
  end
endmodule // tb_epvid_cfg_top
